// file: src/fzps_cfg.svh
// Timing and layout constants for the freeze mode power sequencer
`ifndef FZPS_CFG_SVH
`define FZPS_CFG_SVH
`define FZPS_CLK_HZ 20000000
`define FZPS_HOLD_CYCLES 16
`define FZPS_FILT_CYCLES 4
`define FZPS_SETTLE_CYCLES 10000
`define FZPS_FREEZE_REGION 4'hf
`define FZPS_FSEL_REGION 4'he
`define FZPS_FSEL_W 3
`define FZPS_FSEL_RESET 3'h0
`define FZPS_ADDR_W 28
`endif

// file: src/fzps_pkg.sv
// Sequencer state type, used only by the sequencer end of the freeze mode link
package fzps_pkg;
    typedef enum {
        FZPS_IDLE,
        FZPS_ENTRY_HOLD,
        FZPS_ENTRY_LAST,
        FZPS_FROZEN,
        FZPS_SETTLE,
        FZPS_RECOVER_HOLD
    } fzps_state_e;
endpackage

// file: src/fzps_if.sv
// Interface joining the processor end and the sequencer end
`timescale 1ns/100ps
`include "fzps_cfg.svh"
interface fzps_if;
    logic [`FZPS_ADDR_W-1:0] addr;
    logic address_strobe_n;
    logic write_n_read;
    logic data_enable_n;
    logic [`FZPS_FSEL_W-1:0] wdata;
    logic proc_oe;
    logic proc_reset_n;
    logic freeze_request_n;
    modport proc (
        output addr,
        output address_strobe_n,
        output write_n_read,
        output data_enable_n,
        output wdata,
        output proc_oe,
        input proc_reset_n,
        input freeze_request_n
    );
    modport ctrl (
        input addr,
        input address_strobe_n,
        input write_n_read,
        input data_enable_n,
        input wdata,
        input proc_oe,
        output proc_reset_n,
        output freeze_request_n
    );
endinterface

// file: src/fzps_ctrl.sv
// Freeze mode sequencer: entry decode, wake filter, reset sequencing, clock select port
//
// Function
// - Freeze request held through reset release plus one
// - Frozen processor stops and floats outputs
// - Recovery resets processor with freeze request off
// - Recovery waits external settle timer before release
// - One-bit addressable entry port starts entry
// - Write to region 15 starts entry
// - External wake input starts recovery
// - Wake accepted after several consecutive valid clocks
// - Processor reset separate from system reset
// - Processor reaches low power within few clocks
// - Frozen processor leaves system resources free
// - Chip select latches three frequency select bits
// - Software writes slow or normal select code
// - No wait for frequency reached indication
// - Slow clock never below part minimum; the port latches any select code without a range check
// - Entry: reset low 16 clocks, release, hold one
// - Recovery: timer done, then 16 more clocks
`timescale 1ns/100ps
`include "fzps_cfg.svh"
module fzps_ctrl #(
    parameter int HOLD_CYCLES = `FZPS_HOLD_CYCLES,
    parameter int FILT_CYCLES = `FZPS_FILT_CYCLES
) (
    input wire logic CLOCK,
    input wire logic SRST,
    fzps_if.ctrl BUS,
    input wire logic ENTRY_PORT_WR,
    input wire logic ENTRY_PORT_DATA,
    input wire logic WAKE_IN,
    input wire logic TIMER_DONE,
    output logic TIMER_START,
    output logic FREEZE_MODE,
    output logic [`FZPS_FSEL_W-1:0] FREQ_SEL,
    output logic FREQ_SEL_CS,
    output logic ENTRY_PORT_Q
);
    initial begin
        if (HOLD_CYCLES < 1 || HOLD_CYCLES > 256) $error("HOLD_CYCLES out of range");
        if (FILT_CYCLES < 2 || FILT_CYCLES > 256) $error("FILT_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic wake_s1_r, wake_s2_r, done_s1_r, done_s2_r;
    always_ff @(posedge CLOCK) begin
        wake_s1_r <= WAKE_IN;
        wake_s2_r <= wake_s1_r;
        done_s1_r <= TIMER_DONE;
        done_s2_r <= done_s1_r;
    end

    // ------------------------------------------------------------
    // Wake filter
    // ------------------------------------------------------------
    // Saturating run counter rejects glitches shorter than FILT_CYCLES
    logic [7:0] filt_r, filt_nxt;
    logic wake_ok;
    always_comb begin
        filt_nxt = filt_r;
        if (!wake_s2_r) begin
            filt_nxt = 8'h00;
        end else if (filt_r != 8'(FILT_CYCLES)) begin
            filt_nxt = filt_r + 8'h01;
        end
    end
    assign wake_ok = (filt_r == 8'(FILT_CYCLES));

    // ------------------------------------------------------------
    // Entry decode and frequency select port
    // ------------------------------------------------------------
    logic bus_wr, region_freeze, region_fsel, entry_req;
    logic port_r, port_nxt;
    logic [`FZPS_FSEL_W-1:0] fsel_r, fsel_nxt;
    logic cs_r, cs_nxt;
    assign bus_wr = !BUS.address_strobe_n && BUS.write_n_read && BUS.proc_oe;
    assign region_freeze = BUS.addr[`FZPS_ADDR_W-1 -: 4] == `FZPS_FREEZE_REGION;
    assign region_fsel = BUS.addr[`FZPS_ADDR_W-1 -: 4] == `FZPS_FSEL_REGION;
    // Port bit self clears freeze_request_n the sequence takes it
    assign entry_req = port_r || (bus_wr && region_freeze);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    fzps_pkg::fzps_state_e state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic rst_n_r, rst_n_nxt, frz_n_r, frz_n_nxt, tstart_r, tstart_nxt;
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        port_nxt = port_r;
        fsel_nxt = fsel_r;
        cs_nxt = bus_wr && region_fsel && !BUS.data_enable_n;
        if (cs_nxt) begin
            fsel_nxt = BUS.wdata;
        end
        if (ENTRY_PORT_WR) begin
            port_nxt = ENTRY_PORT_DATA;
        end
        case (state_r)
            fzps_pkg::FZPS_IDLE: begin
                if (entry_req) begin
                    state_nxt = fzps_pkg::FZPS_ENTRY_HOLD;
                    cnt_nxt = 8'h00;
                    port_nxt = 1'b0;
                end
            end
            fzps_pkg::FZPS_ENTRY_HOLD: begin
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == 8'(HOLD_CYCLES - 1)) begin
                    state_nxt = fzps_pkg::FZPS_ENTRY_LAST;
                end
            end
            fzps_pkg::FZPS_ENTRY_LAST: begin
                state_nxt = fzps_pkg::FZPS_FROZEN;
            end
            fzps_pkg::FZPS_FROZEN: begin
                port_nxt = 1'b0;
                if (wake_ok) begin
                    state_nxt = fzps_pkg::FZPS_SETTLE;
                end
            end
            fzps_pkg::FZPS_SETTLE: begin
                if (done_s2_r) begin
                    state_nxt = fzps_pkg::FZPS_RECOVER_HOLD;
                    cnt_nxt = 8'h00;
                end
            end
            fzps_pkg::FZPS_RECOVER_HOLD: begin
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == 8'(HOLD_CYCLES - 1)) begin
                    state_nxt = fzps_pkg::FZPS_IDLE;
                end
            end
            default: state_nxt = fzps_pkg::FZPS_IDLE;
        endcase
        if (state_r != fzps_pkg::FZPS_IDLE) begin
            port_nxt = 1'b0;
        end
        // Outputs registered from next state to keep them glitch free
        rst_n_nxt = (state_nxt == fzps_pkg::FZPS_IDLE) || (state_nxt == fzps_pkg::FZPS_ENTRY_LAST)
            || (state_nxt == fzps_pkg::FZPS_FROZEN);
        frz_n_nxt = !((state_nxt == fzps_pkg::FZPS_ENTRY_HOLD) || (state_nxt == fzps_pkg::FZPS_ENTRY_LAST)
            || (state_nxt == fzps_pkg::FZPS_FROZEN));
        tstart_nxt = state_nxt == fzps_pkg::FZPS_SETTLE;
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state_r <= fzps_pkg::FZPS_IDLE;
            cnt_r <= 8'h00;
            filt_r <= 8'h00;
            port_r <= 1'b0;
            fsel_r <= `FZPS_FSEL_RESET;
            cs_r <= 1'b0;
            rst_n_r <= 1'b0;
            frz_n_r <= 1'b1;
            tstart_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            filt_r <= filt_nxt;
            port_r <= port_nxt;
            fsel_r <= fsel_nxt;
            cs_r <= cs_nxt;
            rst_n_r <= rst_n_nxt;
            frz_n_r <= frz_n_nxt;
            tstart_r <= tstart_nxt;
        end
    end

    assign BUS.proc_reset_n = rst_n_r;
    assign BUS.freeze_request_n = frz_n_r;
    assign TIMER_START = tstart_r;
    assign FREEZE_MODE = state_r == fzps_pkg::FZPS_FROZEN;
    // Select code range is the software's duty; the generator gives no lock flag
    assign FREQ_SEL = fsel_r;
    assign FREQ_SEL_CS = cs_r;
    assign ENTRY_PORT_Q = port_r;
endmodule

// file: src/fzps_proc.sv
// Processor end: bus writes, freeze capture at reset release, output float
`timescale 1ns/100ps
`include "fzps_cfg.svh"
module fzps_proc (
    input wire logic CLOCK,
    input wire logic SRST,
    fzps_if.proc BUS,
    input wire logic WR_REQ,
    input wire logic [`FZPS_ADDR_W-1:0] WR_ADDR,
    input wire logic [`FZPS_FSEL_W-1:0] WR_DATA,
    output logic WR_READY,
    output logic FROZEN,
    output logic IN_RESET
);
    // ------------------------------------------------------------
    // Reset and freeze sampling
    // ------------------------------------------------------------
    logic rst_s1_r, rst_s2_r, frz_s1_r, frz_s2_r;
    logic frozen_r, frozen_nxt, prev_rst_r;
    always_ff @(posedge CLOCK) begin
        rst_s1_r <= BUS.proc_reset_n;
        rst_s2_r <= rst_s1_r;
        frz_s1_r <= BUS.freeze_request_n;
        frz_s2_r <= frz_s1_r;
    end
    always_comb begin
        frozen_nxt = frozen_r;
        if (!rst_s2_r) begin
            frozen_nxt = 1'b0;
        end else if (!prev_rst_r && !frz_s2_r) begin
            frozen_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Bus cycle generator
    // ------------------------------------------------------------
    logic ads_n_r, ads_n_nxt;
    logic [`FZPS_ADDR_W-1:0] addr_r, addr_nxt;
    logic [`FZPS_FSEL_W-1:0] data_r, data_nxt;
    logic active;
    assign active = rst_s2_r && !frozen_r;
    assign WR_READY = active && ads_n_r;
    always_comb begin
        ads_n_nxt = 1'b1;
        addr_nxt = addr_r;
        data_nxt = data_r;
        if (WR_REQ && WR_READY) begin
            ads_n_nxt = 1'b0;
            addr_nxt = WR_ADDR;
            data_nxt = WR_DATA;
        end
    end
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            frozen_r <= 1'b0;
            prev_rst_r <= 1'b0;
            ads_n_r <= 1'b1;
            addr_r <= '0;
            data_r <= '0;
        end else begin
            frozen_r <= frozen_nxt;
            prev_rst_r <= rst_s2_r;
            ads_n_r <= ads_n_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
        end
    end

    // Floated pins read as pulled-up strobes at the far end
    assign BUS.proc_oe = active;
    assign BUS.address_strobe_n = active ? ads_n_r : 1'b1;
    assign BUS.data_enable_n = active ? ads_n_r : 1'b1;
    assign BUS.write_n_read = active;
    assign BUS.addr = addr_r;
    assign BUS.wdata = data_r;
    assign FROZEN = frozen_r;
    assign IN_RESET = !rst_s2_r;
endmodule

// file: test/fzps_sva.sv
// Checker for the freeze sequencer link
`timescale 1ns/100ps
`include "fzps_cfg.svh"
module fzps_sva (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic [`FZPS_ADDR_W-1:0] addr,
    input wire logic address_strobe_n,
    input wire logic write_n_read,
    input wire logic proc_oe,
    input wire logic proc_reset_n,
    input wire logic freeze_request_n,
    input wire logic WAKE_IN,
    input wire logic TIMER_START,
    input wire logic TIMER_DONE
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);
    wire idle = proc_reset_n && freeze_request_n;
    wire frz = proc_reset_n && !freeze_request_n;
    // ----------
    // Helper counters
    // ----------
    // Long holds are counted here instead of unrolled repetitions
    logic [4:0] low_cnt;
    logic [4:0] rec_cnt;
    logic rec_armed;
    always_ff @(posedge CLOCK) begin
        if (SRST || proc_reset_n) begin
            low_cnt <= 5'h00;
        end else if (low_cnt != 5'h1f) begin
            low_cnt <= low_cnt + 5'h01;
        end
        if (SRST || proc_reset_n || TIMER_START || !freeze_request_n) begin
            rec_cnt <= 5'h00;
        end else if (rec_cnt != 5'h1f) begin
            rec_cnt <= rec_cnt + 5'h01;
        end
        if (SRST || proc_reset_n) begin
            rec_armed <= 1'b0;
        end else if (TIMER_START) begin
            rec_armed <= 1'b1;
        end
    end
    // ----------
    // Properties
    // ----------
    // Reset check must run while reset is high
    property p_rst;
        disable iff (1'b0) SRST |=> !proc_reset_n && freeze_request_n;
    endproperty
    property p_entry;
        idle && !address_strobe_n && write_n_read && addr[27:24] == `FZPS_FREEZE_REGION
            |=> !proc_reset_n && !freeze_request_n;
    endproperty
    property p_hold;
        $rose(proc_reset_n) && !freeze_request_n |-> low_cnt == 5'h10;
    endproperty
    property p_stay;
        frz |=> !freeze_request_n || !proc_reset_n;
    endproperty
    property p_wake;
        $rose(TIMER_START) |-> $past(WAKE_IN, 4) && $past(WAKE_IN, 7) && $past(frz);
    endproperty
    property p_settle;
        TIMER_START |-> !proc_reset_n && freeze_request_n;
    endproperty
    property p_wait;
        TIMER_START && !TIMER_DONE |=> TIMER_START;
    endproperty
    property p_recover;
        $rose(proc_reset_n) && rec_armed |-> freeze_request_n && rec_cnt == 5'h10;
    endproperty
    property p_float;
        frz[*6] |-> !proc_oe;
    endproperty
    a_rst: assert property (p_rst) else $error("processor reset not forced");
    a_entry: assert property (p_entry) else $error("entry write not taken");
    a_hold: assert property (p_hold) else $error("entry hold wrong");
    a_stay: assert property (p_stay) else $error("freeze request dropped early");
    a_wake: assert property (p_wake) else $error("wake not filtered");
    a_settle: assert property (p_settle) else $error("settle levels wrong");
    a_wait: assert property (p_wait) else $error("timer start dropped early");
    a_recover: assert property (p_recover) else $error("recovery hold wrong");
    a_float: assert property (p_float) else $error("frozen processor drives");
    c_entry: cover property ($fell(freeze_request_n));
    c_wake: cover property ($rose(TIMER_START));
    c_back: cover property ($fell(TIMER_START));
endmodule

// file: test/fzps_test.sv
// Self-checking bench for the freeze sequencer pair
`timescale 1ns/100ps
`include "fzps_cfg.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module fzps_test;
    logic clock, srst, wake, tdone, ep_wr, ep_data, wr_req, wr_ready, frozen, in_reset;
    logic timer_start, freeze_mode, fsel_cs, ep_q;
    logic [`FZPS_ADDR_W-1:0] wr_addr;
    logic [`FZPS_FSEL_W-1:0] wr_data, fsel, fsel_exp, d;
    logic [3:0] rg;
    logic [31:0] seed = 32'h000135be;
    logic [31:0] r;
    int failures = 0, comparisons = 0, cycles = 0, n;
    fzps_if fzps_if_i ();
    fzps_ctrl #(.HOLD_CYCLES(16), .FILT_CYCLES(4)) fzps_ctrl_i (.CLOCK(clock), .SRST(srst), .BUS(fzps_if_i.ctrl),
        .ENTRY_PORT_WR(ep_wr), .ENTRY_PORT_DATA(ep_data), .WAKE_IN(wake), .TIMER_DONE(tdone),
        .TIMER_START(timer_start), .FREEZE_MODE(freeze_mode), .FREQ_SEL(fsel), .FREQ_SEL_CS(fsel_cs),
        .ENTRY_PORT_Q(ep_q));
    fzps_proc fzps_proc_i (.CLOCK(clock), .SRST(srst), .BUS(fzps_if_i.proc), .WR_REQ(wr_req), .WR_ADDR(wr_addr),
        .WR_DATA(wr_data), .WR_READY(wr_ready), .FROZEN(frozen), .IN_RESET(in_reset));
    fzps_sva fzps_sva_i (.CLOCK(clock), .SRST(srst), .addr(fzps_if_i.addr),
        .address_strobe_n(fzps_if_i.address_strobe_n), .write_n_read(fzps_if_i.write_n_read),
        .proc_oe(fzps_if_i.proc_oe), .proc_reset_n(fzps_if_i.proc_reset_n),
        .freeze_request_n(fzps_if_i.freeze_request_n), .WAKE_IN(wake), .TIMER_START(timer_start),
        .TIMER_DONE(tdone));
    // -------
    // Helpers
    // -------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [2:0] exp_fsel(input logic [3:0] g, input logic [2:0] v, input logic [2:0] old);
        return (g == `FZPS_FSEL_REGION) ? v : old;
    endfunction
    task automatic cyc(input int k = 1);
        repeat (k) @(posedge clock);
        #2;
    endtask
    task automatic wr(input logic [27:0] a, input logic [2:0] v);
        int i;
        wr_req = 1;
        wr_addr = a;
        wr_data = v;
        i = 0;
        while (wr_ready !== 1'b1 && i < 20) begin cyc(); i++; end
        cyc();
        wr_req = 0;
    endtask
    task automatic low_len(output int k);
        int i;
        i = 0;
        while (fzps_if_i.proc_reset_n !== 1'b0 && i < 10) begin cyc(); i++; end
        k = 0;
        while (fzps_if_i.proc_reset_n === 1'b0 && k < 100) begin cyc(); k++; end
    endtask
    task automatic enter(input bit by_port);
        r = rnd();
        if (by_port) begin
            ep_wr = 1;
            ep_data = 1;
            cyc();
            ep_wr = 0;
            `CHK(ep_q, 1'b1)
        end else wr({`FZPS_FREEZE_REGION, r[23:0]}, r[26:24]);
        low_len(n);
        `CHK(n, 16)
        `CHK(fzps_if_i.freeze_request_n, 1'b0)
        cyc(6);
        `CHK({frozen, freeze_mode, fzps_if_i.proc_oe}, 3'b110)
        `CHK(fsel, fsel_exp)
        $display("entry test done");
    endtask
    task automatic recover(input int settle);
        int i;
        wake = 1;
        i = 0;
        while (timer_start !== 1'b1 && i < 20) begin cyc(); i++; end
        wake = 0;
        `CHK(i >= 5, 1'b1)
        cyc(settle);
        `CHK({timer_start, fzps_if_i.proc_reset_n}, 2'b10)
        tdone = 1;
        low_len(n);
        tdone = 0;
        `CHK(n >= 17 && n <= 20, 1'b1)
        cyc(6);
        `CHK({frozen, freeze_mode, fzps_if_i.freeze_request_n}, 3'b001)
        $display("recovery test done");
    endtask
    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // --------
    // Sequence
    // --------
    initial begin
        clock = 0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        {srst, wake, tdone, ep_wr, ep_data, wr_req} = 6'h20;
        wr_addr = '0;
        wr_data = '0;
        cyc(6);
        `CHK({fzps_if_i.proc_reset_n, fzps_if_i.freeze_request_n, in_reset, fsel}, 6'h18)
        srst = 0;
        cyc(4);
        fsel_exp = `FZPS_FSEL_RESET;
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            rg = (i < 8) ? `FZPS_FSEL_REGION : r[31:28] % `FZPS_FSEL_REGION;
            d = (i < 8) ? 3'(i) : r[26:24];
            wr({rg, r[23:0]}, d);
            fsel_exp = exp_fsel(rg, d, fsel_exp);
            cyc();
            `CHK(fsel_cs, rg == `FZPS_FSEL_REGION)
            cyc();
            `CHK(fsel, fsel_exp)
            `CHK(fzps_if_i.proc_reset_n, 1'b1)
        end
        $display("select test done");
        wake = 1;
        cyc(12);
        wake = 0;
        cyc(2);
        `CHK(timer_start, 1'b0)
        enter(0);
        wake = 1;
        cyc(2);
        wake = 0;
        cyc(10);
        `CHK(timer_start, 1'b0)
        recover(40 + rnd() % 64);
        enter(1);
        ep_wr = 1;
        cyc();
        ep_wr = 0;
        cyc();
        `CHK(ep_q, 1'b0)
        recover(20);
        r = rnd();
        wr({`FZPS_FREEZE_REGION, r[23:0]}, r[2:0]);
        cyc(5);
        srst = 1;
        cyc(3);
        `CHK({fzps_if_i.proc_reset_n, fzps_if_i.freeze_request_n, timer_start, fsel}, 6'h10)
        srst = 0;
        $display("reset test done");
        finish_test();
    end
endmodule
